// ---- verilog/ute_pkg.sv ----
// package: register map, field positions, source codes and states
package ute_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00; // command pulses
	localparam logic [7:0] OFS_CFG = 8'h04; // mode and source selection
	localparam logic [7:0] OFS_DIV = 8'h08; // timebase divisor
	localparam logic [7:0] OFS_DLY = 8'h0c; // launch to first sample delay
	localparam logic [7:0] OFS_NSAMP = 8'h10; // finite sample count
	localparam logic [7:0] OFS_FILT = 8'h14; // glitch filter length
	localparam logic [7:0] OFS_PINDIR = 8'h18; // pin direction, 1 = output
	localparam logic [7:0] OFS_PINRT = 8'h1c; // pin route, 1 = launch
	localparam logic [7:0] OFS_STAT = 8'h20; // status, underflow w1c
	localparam logic [7:0] OFS_CNT = 8'h24; // samples issued

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_START = 0; // arm a generation
	localparam int CTRL_STOP = 1; // stop and disarm
	localparam int CTRL_SWTRIG = 2; // software launch pulse
	localparam int CFG_EXT_STB = 0; // strobe from a pin
	localparam int CFG_EXT_TB = 1; // timebase from a pin
	localparam int CFG_TRIG_EN = 2; // wait for a launch edge
	localparam int CFG_TRIG_FALL = 3; // launch on falling edge
	localparam int CFG_TSEL = 4; // launch source, 4 bits
	localparam int CFG_HOLD_EN = 8; // hold gate in use
	localparam int CFG_HOLD_LOW = 9; // low level holds
	localparam int CFG_HSEL = 10; // hold source, 4 bits
	localparam int CFG_FINITE = 14; // stop after the sample count
	localparam int CFG_NONREGEN = 15; // check for fresh samples
	localparam int CFG_STB_INV = 16; // routed strobe active low
	localparam int CFG_FLT = 17; // filter enables, 3 bits
	localparam int CFG_SSEL = 20; // strobe pin, 4 bits
	localparam int CFG_TBSEL = 24; // timebase pin, 4 bits
	localparam int ST_ARMED = 0; // status bit positions
	localparam int ST_DELAY = 1;
	localparam int ST_RUN = 2;
	localparam int ST_DONE = 3;
	localparam int ST_UNDER = 4;

	// ------------------------------------------------------------
	// source codes and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] TSRC_SW = 4'h0; // software pulse
	localparam logic [3:0] TSRC_REF = 4'h1; // acquisition reference
	localparam logic [3:0] TSRC_ACQ = 4'h2; // acquisition start
	localparam logic [3:0] TSRC_LVL = 4'h3; // level compare event
	localparam logic [3:0] TSRC_INT = 4'h4; // internal signal
	localparam logic [3:0] HSRC_LVL = 4'h0; // level compare event
	localparam logic [3:0] HSRC_INT = 4'h1; // internal signal
	localparam logic [3:0] SRC_PIN0 = 4'h8; // pins start here
	localparam logic [31:0] RST_CFG = 32'h0000_0000; // filters off
	localparam logic [7:0] RST_FILT = 8'h01; // filter length

	// ------------------------------------------------------------
	// engine states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_ARMED = 4'h2,
		S_DELAY = 4'h4,
		S_RUN = 4'h8
	} ute_state_t;

endpackage

// ---- verilog/ute_div_if.sv ----
// interface: engine to strobe divider
`timescale 1ns/1ps
interface ute_div_if #(parameter int DW = 16);
	// divider control and result
	logic tb_tick; // one timebase tick
	logic run; // count ticks
	logic restart; // clear the count
	logic [DW-1:0] divisor; // ticks per strobe
	logic tick; // strobe due
	modport eng (output tb_tick, run, restart, divisor, input tick);
	modport div (input tb_tick, run, restart, divisor, output tick);
endinterface

// ---- verilog/ute_glitch_filter.sv ----
// glitch filter: passes a level after n equal samples
`timescale 1ns/1ps
module ute_glitch_filter (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// control
	input wire logic en,
	input wire logic [7:0] len,
	// signal
	input wire logic raw,
	output logic lvl
);
	typedef struct packed {
		logic lvl; // propagated level
		logic [7:0] cnt; // equal samples seen
	} ute_flt_t;
	ute_flt_t q, d;

	// count consecutive samples of the new level
	always_comb begin
		d = q;
		if (!en || raw == q.lvl) begin
			d.lvl = en ? q.lvl : raw;
			d.cnt = 8'h00;
		end else if (q.cnt + 8'h01 >= len) begin
			d.lvl = raw;
			d.cnt = 8'h00;
		end else begin
			d.cnt = q.cnt + 8'h01;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lvl = q.lvl;

	AST_FLT_STEADY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(en && len >= 8'h02 && $past(en) && $changed(q.lvl)) |->
		$past(raw) == q.lvl && $past(q.cnt) != 8'h00)
		else $error("filtered level changed without a run of samples");
endmodule

// ---- verilog/ute_strobe_div.sv ----
// strobe divider: one tick per divisor timebase ticks
`timescale 1ns/1ps
module ute_strobe_div #(parameter int DW = 16) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// engine side
	ute_div_if.div dv
);
	typedef struct packed {
		logic [DW-1:0] cnt; // ticks since last strobe
	} ute_dcnt_t;
	ute_dcnt_t q, d;
	logic last;

	// a zero divisor behaves as one
	assign last = (q.cnt + DW'(1) >= dv.divisor);

	// count timebase ticks while running; cleared on restart, frozen otherwise
	always_comb begin
		d = q;
		if (dv.restart) begin
			d.cnt = '0;
		end else if (dv.run && dv.tb_tick) begin
			d.cnt = last ? '0 : q.cnt + DW'(1);
		end
	end

	assign dv.tick = dv.run && dv.tb_tick && !dv.restart && last;

	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	AST_DIV_PERIOD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(dv.tick && dv.divisor == DW'(3)) |-> q.cnt == DW'(2))
		else $error("divider ticked at the wrong count");
endmodule

// ---- verilog/ute_engine.sv ----
// output update timing engine: launch, hold, strobe and apb registers
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ute_engine #(
	parameter int NPIN = 8, // programmable pins
	parameter int SW = 32, // channels per sample
	parameter int DW = 16 // divisor and delay width
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// trigger sources
	input wire logic acquisition_reference_trigger,
	input wire logic acquisition_start_trigger,
	input wire logic level_compare_event,
	input wire logic internal_launch,
	input wire logic internal_hold,
	// programmable pins
	input wire logic [NPIN-1:0] programmable_pin_i,
	output logic [NPIN-1:0] programmable_pin_o,
	output logic [NPIN-1:0] programmable_pin_oe_n,
	// sample source and channel outputs
	input wire logic sample_valid,
	input wire logic [SW-1:0] sample_data,
	output logic sample_take,
	output logic [SW-1:0] channel_out,
	output logic output_update_strobe
);
	initial begin
		if (NPIN < 1 || NPIN > 8 || DW < 2 || DW > 32 || SW < 1 || SW > 32)
			$error("ute_engine: unsupported parameter value");
	end

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_r; // release synchroniser
	logic rst_n; // released reset

	// two flops release the reset in step with the clock
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic pready; // access phase answered
		logic [31:0] prdata; // read data
		logic pslverr; // unmapped access
		logic [31:0] cfg; // configuration
		logic [DW-1:0] div; // divisor
		logic [DW-1:0] dly; // delay in timebase ticks
		logic [31:0] nsamp; // finite count
		logic [7:0] flen; // filter length
		logic [NPIN-1:0] pdir; // pin directions
		logic [NPIN-1:0] prt; // pin routes
		ute_pkg::ute_state_t st; // engine state
		logic [DW-1:0] dcnt; // delay remaining
		logic [31:0] scnt; // samples issued
		logic first; // first internal sample due
		logic under; // sticky underflow
		logic done; // finite run complete
		logic trig_d; // launch level last cycle
		logic stb_d; // strobe pin last cycle
		logic tb_d; // timebase pin last cycle
		logic strobe; // update strobe pulse
		logic launch; // launch pulse
		logic take; // sample consumed
		logic [SW-1:0] dout; // channel outputs
		logic [NPIN-1:0] pin_o; // pin drive
		logic [NPIN-1:0] pin_oen; // pin enable, low drives
	} ute_state_all_t;
	ute_state_all_t q, d;

	// ------------------------------------------------------------
	// source selection and filters
	// ------------------------------------------------------------
	logic [3:0] tsel, hsel, ssel, tbsel;
	logic [2:0] raw, flt; // strobe, launch, hold
	logic ext_stb, tb_tick, stb_edge, trig_edge, hold_act;
	logic start_cmd, stop_cmd, sw_trig, access, sample_hit;

	assign tsel = q.cfg[ute_pkg::CFG_TSEL +: 4];
	assign hsel = q.cfg[ute_pkg::CFG_HSEL +: 4];
	assign ssel = q.cfg[ute_pkg::CFG_SSEL +: 4];
	assign tbsel = q.cfg[ute_pkg::CFG_TBSEL +: 4];
	assign ext_stb = q.cfg[ute_pkg::CFG_EXT_STB];

	// pick the raw launch, hold and strobe levels
	always_comb begin
		raw[0] = programmable_pin_i[ssel[2:0]];
		case (tsel)
			ute_pkg::TSRC_REF: raw[1] = acquisition_reference_trigger;
			ute_pkg::TSRC_ACQ: raw[1] = acquisition_start_trigger;
			ute_pkg::TSRC_LVL: raw[1] = level_compare_event;
			ute_pkg::TSRC_INT: raw[1] = internal_launch;
			default: raw[1] = tsel[3] && programmable_pin_i[tsel[2:0]];
		endcase
		case (hsel)
			ute_pkg::HSRC_LVL: raw[2] = level_compare_event;
			ute_pkg::HSRC_INT: raw[2] = internal_hold;
			default: raw[2] = hsel[3] && programmable_pin_i[hsel[2:0]];
		endcase
	end

	// optional glitch filter on strobe, launch and hold
	for (genvar g = 0; g < 3; g++) begin : g_flt
		ute_glitch_filter u_flt (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.en(q.cfg[ute_pkg::CFG_FLT + g]),
			.len(q.flen),
			.raw(raw[g]),
			.lvl(flt[g])
		);
	end

	// timebase: every clock, or rising pin edges with no filter
	assign tb_tick = q.cfg[ute_pkg::CFG_EXT_TB] ?
		(programmable_pin_i[tbsel[2:0]] && !q.tb_d) : 1'b1;
	assign stb_edge = flt[0] && !q.stb_d;
	assign trig_edge = (tsel == ute_pkg::TSRC_SW) ? sw_trig :
		(q.cfg[ute_pkg::CFG_TRIG_FALL] ? (q.trig_d && !flt[1]) :
		(!q.trig_d && flt[1]));
	assign hold_act = q.cfg[ute_pkg::CFG_HOLD_EN] &&
		(flt[2] != q.cfg[ute_pkg::CFG_HOLD_LOW]);

	// ------------------------------------------------------------
	// strobe divider
	// ------------------------------------------------------------
	ute_div_if #(.DW(DW)) dvi ();

	assign dvi.tb_tick = tb_tick;
	// the divider freezes during hold and resumes at once after it
	assign dvi.run = (q.st == ute_pkg::S_RUN) && !ext_stb && !hold_act;
	// the count starts after the first sample, a full period before the next
	assign dvi.restart = (q.st != ute_pkg::S_RUN) || q.first;
	assign dvi.divisor = q.div;

	ute_strobe_div #(.DW(DW)) u_div (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.dv(dvi)
	);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	assign access = psel && penable && q.pready;
	assign start_cmd = access && pwrite && paddr == ute_pkg::OFS_CTRL &&
		pwdata[ute_pkg::CTRL_START];
	assign stop_cmd = access && pwrite && paddr == ute_pkg::OFS_CTRL &&
		pwdata[ute_pkg::CTRL_STOP];
	assign sw_trig = access && pwrite && paddr == ute_pkg::OFS_CTRL &&
		pwdata[ute_pkg::CTRL_SWTRIG];

	// a sample is due on a strobe that finds the hold gate inactive
	assign sample_hit = (q.st == ute_pkg::S_RUN) && !hold_act &&
		(ext_stb ? stb_edge : (dvi.tick || q.first));

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.trig_d = flt[1];
		d.stb_d = flt[0];
		d.tb_d = programmable_pin_i[tbsel[2:0]];
		d.strobe = 1'b0;
		d.launch = 1'b0;
		d.take = 1'b0;
		d.pslverr = 1'b0;
		// one wait state: answer in the second access cycle
		d.pready = psel && penable && !q.pready;
		if (psel && penable && !q.pready) begin
			d.pslverr = (paddr > ute_pkg::OFS_CNT) || (paddr[1:0] != 2'h0);
			case (paddr)
				ute_pkg::OFS_CFG: d.prdata = q.cfg;
				ute_pkg::OFS_DIV: d.prdata = 32'(q.div);
				ute_pkg::OFS_DLY: d.prdata = 32'(q.dly);
				ute_pkg::OFS_NSAMP: d.prdata = q.nsamp;
				ute_pkg::OFS_FILT: d.prdata = 32'(q.flen);
				ute_pkg::OFS_PINDIR: d.prdata = 32'(q.pdir);
				ute_pkg::OFS_PINRT: d.prdata = 32'(q.prt);
				ute_pkg::OFS_STAT: d.prdata = {27'h0, q.under, q.done,
					q.st == ute_pkg::S_RUN, q.st == ute_pkg::S_DELAY,
					q.st == ute_pkg::S_ARMED};
				ute_pkg::OFS_CNT: d.prdata = q.scnt;
				default: d.prdata = 32'h0000_0000;
			endcase
		end
		// register writes take effect at the answering edge
		if (access && pwrite) begin
			case (paddr)
				ute_pkg::OFS_CFG: d.cfg = pwdata;
				ute_pkg::OFS_DIV: d.div = pwdata[DW-1:0];
				ute_pkg::OFS_DLY: d.dly = pwdata[DW-1:0];
				ute_pkg::OFS_NSAMP: d.nsamp = pwdata;
				ute_pkg::OFS_FILT: d.flen = pwdata[7:0];
				ute_pkg::OFS_PINDIR: d.pdir = pwdata[NPIN-1:0];
				ute_pkg::OFS_PINRT: d.prt = pwdata[NPIN-1:0];
				ute_pkg::OFS_STAT:
					if (pwdata[ute_pkg::ST_UNDER]) d.under = 1'b0;
				default: d.cfg = q.cfg;
			endcase
		end
		// engine sequence
		case (q.st)
			ute_pkg::S_IDLE: begin
				if (start_cmd) begin
					d.scnt = 32'h0000_0000;
					d.done = 1'b0;
					d.st = ute_pkg::S_ARMED;
				end
			end
			ute_pkg::S_ARMED: begin
				// untriggered starts launch in the cycle after the start command arms
				if (!q.cfg[ute_pkg::CFG_TRIG_EN] || trig_edge) begin
					d.launch = 1'b1;
					d.dcnt = q.dly;
					d.first = !ext_stb;
					d.st = (!ext_stb && q.dly != '0) ?
						ute_pkg::S_DELAY : ute_pkg::S_RUN;
				end
			end
			ute_pkg::S_DELAY: begin
				if (tb_tick) begin
					d.dcnt = q.dcnt - DW'(1);
					if (q.dcnt == DW'(1)) d.st = ute_pkg::S_RUN;
				end
			end
			ute_pkg::S_RUN: begin
				// later launch edges are ignored here
				if (sample_hit) begin
					d.first = 1'b0;
					d.strobe = 1'b1;
					d.take = sample_valid;
					if (sample_valid) d.dout = sample_data;
					if (q.cfg[ute_pkg::CFG_NONREGEN] && !sample_valid)
						d.under = 1'b1;
					d.scnt = q.scnt + 32'h1;
					if (q.cfg[ute_pkg::CFG_FINITE] &&
						q.scnt + 32'h1 >= q.nsamp) begin
						d.done = 1'b1;
						d.st = ute_pkg::S_IDLE;
					end
				end
			end
			default: d.st = ute_pkg::S_IDLE;
		endcase
		if (stop_cmd) begin
			d.first = 1'b0;
			d.st = ute_pkg::S_IDLE;
		end
		// pin drive: routed strobe or launch; timebase never leaves
		for (int i = 0; i < NPIN; i++) begin
			d.pin_oen[i] = !q.pdir[i];
			d.pin_o[i] = q.pdir[i] && (q.prt[i] ? d.launch :
				(d.strobe ^ q.cfg[ute_pkg::CFG_STB_INV]));
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{pready: 1'b0, prdata: 32'h0, pslverr: 1'b0,
				cfg: ute_pkg::RST_CFG, div: '0, dly: '0, nsamp: 32'h0,
				flen: ute_pkg::RST_FILT, pdir: '0, prt: '0,
				st: ute_pkg::S_IDLE, dcnt: '0, scnt: 32'h0, first: 1'b0,
				under: 1'b0, done: 1'b0, trig_d: 1'b0, stb_d: 1'b0,
				tb_d: 1'b0, strobe: 1'b0, launch: 1'b0, take: 1'b0,
				dout: '0, pin_o: '0, pin_oen: '1};
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign programmable_pin_o = q.pin_o;
	assign programmable_pin_oe_n = q.pin_oen;
	assign sample_take = q.take;
	assign channel_out = q.dout;
	assign output_update_strobe = q.strobe;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_STROBE_AFTER_LAUNCH: assert property (
		q.strobe |-> $past(q.st) == ute_pkg::S_RUN)
		else $error("strobe issued outside a run");
	AST_CHANNELS_TOGETHER: assert property (
		(q.strobe && q.take) |-> q.dout == $past(sample_data))
		else $error("channels not updated with the strobe");
	AST_HOLD_SUPPRESSES: assert property (
		$past(hold_act) |-> !q.strobe)
		else $error("sample issued while held");
	AST_RUN_IGNORES_TRIG: assert property (
		(q.st == ute_pkg::S_RUN && trig_edge && !start_cmd) |=>
		!q.launch)
		else $error("launch repeated during a run");
	AST_UNDERFLOW_FLAG: assert property (
		(sample_hit && q.cfg[ute_pkg::CFG_NONREGEN] && !sample_valid)
		|=> q.under [*2])
		else $error("underflow not flagged");
	AST_FINITE_STOP: assert property (
		$rose(q.done) |-> q.st == ute_pkg::S_IDLE && q.scnt == $past(
		q.scnt) + 32'h1)
		else $error("finite run did not stop on its count");
	AST_LAUNCH_ONE_PULSE: assert property (
		q.launch |=> !q.launch)
		else $error("launch pulse longer than one cycle");
	AST_SW_START: assert property (
		(q.st == ute_pkg::S_ARMED && !q.cfg[ute_pkg::CFG_TRIG_EN])
		|=> q.launch ##1 q.st != ute_pkg::S_ARMED)
		else $error("software start did not launch");
	AST_FIRST_AFTER_DELAY: assert property (
		(q.st == ute_pkg::S_DELAY && q.dcnt == DW'(1) && tb_tick &&
		!stop_cmd && !hold_act) |=> q.first)
		else $error("first sample not due after the delay");
endmodule

// ---- bench/ute_pin_source.sv ----
// partner model: external launch and strobe sources on the pins
`timescale 1ns/1ps
module ute_pin_source (
	// clock
	input wire logic ref_clk,
	// pin levels toward the engine
	output logic [7:0] pin
);
	// idle sources hold their lines low, a driven low level
	initial pin = 8'h00;

	// n pulses of w cycles on line k, each followed by w low cycles
	task automatic pulse(input int k, input int w, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			pin[k] <= 1'b1;
			repeat (w) @(posedge ref_clk);
			pin[k] <= 1'b0;
			repeat (w) @(posedge ref_clk);
		end
	endtask
endmodule

// ---- bench/test_output_update_timing_engine.sv ----
// testbench: launch, hold and strobe scenarios driven over apb
`timescale 1ns/1ps
module test_output_update_timing_engine;
	// ------------------------------------------------------------
	// clock, reset, bus, sources and counters
	// ------------------------------------------------------------
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic internal_hold, sample_valid, sample_take, output_update_strobe;
	logic lvl_evt; // level compare event toward the engine
	logic [7:0] paddr, pin_i, pin_o, pin_oe_n;
	logic [31:0] pwdata, prdata, rd, sample_data, channel_out;
	int num_errors, n_compared, nstb, gap, since, ntake, np3, np4;

	// engine with the acquisition triggers left idle
	ute_engine DUT (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acquisition_reference_trigger(1'b0),
		.acquisition_start_trigger(1'b0), .level_compare_event(lvl_evt),
		.internal_launch(1'b0), .internal_hold(internal_hold),
		.programmable_pin_i(pin_i), .programmable_pin_o(pin_o),
		.programmable_pin_oe_n(pin_oe_n), .sample_valid(sample_valid),
		.sample_data(sample_data), .sample_take(sample_take),
		.channel_out(channel_out),
		.output_update_strobe(output_update_strobe));
	ute_pin_source u_src (.ref_clk(ref_clk), .pin(pin_i));

	// 100 ns clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// monitor on the falling edge, away from the bench's own updates
	always @(negedge ref_clk) begin
		since++;
		if (output_update_strobe === 1'b1) begin
			nstb++;
			gap = since;
			since = 0;
		end
		if (sample_take === 1'b1) ntake++;
		if (pin_o[3] === 1'b1) np3++;
		if (pin_o[4] === 1'b1) np4++;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task end_of_test;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic c, input string m);
		n_compared++;
		if (c !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task clr;
		nstb = 0;
		ntake = 0;
		np3 = 0;
		np4 = 0;
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			chk(1'b0, "bus timeout");
			end_of_test();
		end
	endtask

	// bounded wait for n strobes, then let the engine settle
	task automatic wait_stb(input int n);
		int i;
		for (i = 0; i < 300 && nstb < n; i++) @(posedge ref_clk);
		if (i == 300) begin
			chk(1'b0, "strobe timeout");
			end_of_test();
		end
		repeat (10) @(posedge ref_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		chk(output_update_strobe === 1'b0 && pin_oe_n === 8'hff, "rst out");
		apb(1'b0, ute_pkg::OFS_CFG, 32'h0);
		chk(rd === ute_pkg::RST_CFG, "cfg reset");
		apb(1'b0, ute_pkg::OFS_FILT, 32'h0);
		chk(rd === {24'h0, ute_pkg::RST_FILT}, "filter reset");
		apb(1'b1, 8'h40, 32'hffff_ffff);
		apb(1'b0, 8'h40, 32'h0);
		chk(rerr === 1'b1 && rd === 32'h0, "unmapped access");
	endtask

	task t_finite;
		sample_data <= 32'ha5a5_5a5a;
		apb(1'b1, ute_pkg::OFS_DIV, 32'h3);
		apb(1'b1, ute_pkg::OFS_DLY, 32'h3);
		apb(1'b1, ute_pkg::OFS_NSAMP, 32'h3);
		apb(1'b1, ute_pkg::OFS_CFG, 32'h1 << ute_pkg::CFG_FINITE);
		clr();
		apb(1'b1, ute_pkg::OFS_CTRL, 32'h1 << ute_pkg::CTRL_START);
		// armed, launch, three delay ticks, then the first strobe
		repeat (5) @(posedge ref_clk);
		chk(nstb == 0, "launch delay");
		@(posedge ref_clk);
		chk(nstb == 1, "first after delay");
		wait_stb(3);
		chk(nstb == 3 && ntake == 3, "finite count");
		chk(gap == 3, "strobe spacing");
		chk(channel_out === 32'ha5a5_5a5a, "channels");
		apb(1'b0, ute_pkg::OFS_STAT, 32'h0);
		chk(rd[ute_pkg::ST_DONE] === 1'b1, "done flag");
	endtask

	task t_pin_launch;
		apb(1'b1, ute_pkg::OFS_PINDIR, 32'h08);
		apb(1'b1, ute_pkg::OFS_PINRT, 32'h08);
		apb(1'b1, ute_pkg::OFS_NSAMP, 32'h6);
		apb(1'b1, ute_pkg::OFS_CFG, (32'h1 << ute_pkg::CFG_FINITE) |
			(32'h1 << ute_pkg::CFG_TRIG_EN) | (32'h9 << ute_pkg::CFG_TSEL));
		clr();
		apb(1'b1, ute_pkg::OFS_CTRL, 32'h1 << ute_pkg::CTRL_START);
		repeat (10) @(posedge ref_clk);
		chk(nstb == 0 && pin_oe_n === 8'hf7, "armed wait");
		// the second edge arrives while the run is still going
		u_src.pulse(1, 3, 2);
		wait_stb(6);
		chk(np3 == 1, "routed launch pulse");
		repeat (10) @(posedge ref_clk);
		chk(nstb == 6, "late launch edge");
	endtask

	task t_level;
		lvl_evt <= 1'b1;
		apb(1'b1, ute_pkg::OFS_NSAMP, 32'h1);
		apb(1'b1, ute_pkg::OFS_CFG, (32'h1 << ute_pkg::CFG_FINITE) |
			(32'h1 << ute_pkg::CFG_TRIG_EN) |
			(32'h1 << ute_pkg::CFG_TRIG_FALL) |
			(32'(ute_pkg::TSRC_LVL) << ute_pkg::CFG_TSEL));
		clr();
		apb(1'b1, ute_pkg::OFS_CTRL, 32'h1 << ute_pkg::CTRL_START);
		repeat (5) @(posedge ref_clk);
		chk(nstb == 0, "level armed");
		lvl_evt <= 1'b0;
		wait_stb(1);
		chk(nstb == 1 && np3 == 1, "level falling launch");
	endtask

	task t_hold;
		sample_valid <= 1'b0;
		internal_hold <= 1'b1;
		apb(1'b1, ute_pkg::OFS_CFG, (32'h1 << ute_pkg::CFG_HOLD_EN) |
			(32'h1 << ute_pkg::CFG_HSEL) | (32'h1 << ute_pkg::CFG_NONREGEN));
		clr();
		apb(1'b1, ute_pkg::OFS_CTRL, 32'h1 << ute_pkg::CTRL_START);
		repeat (20) @(posedge ref_clk);
		chk(nstb == 0, "held");
		internal_hold <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk(nstb > 0, "resume");
		apb(1'b0, ute_pkg::OFS_STAT, 32'h0);
		chk(rd[ute_pkg::ST_UNDER] === 1'b1, "underflow");
		chk(channel_out === 32'ha5a5_5a5a, "kept outputs");
		apb(1'b1, ute_pkg::OFS_CTRL, 32'h1 << ute_pkg::CTRL_STOP);
		sample_valid <= 1'b1;
	endtask

	task t_ext_strobe;
		apb(1'b1, ute_pkg::OFS_PINDIR, 32'h10);
		apb(1'b1, ute_pkg::OFS_PINRT, 32'h0);
		apb(1'b1, ute_pkg::OFS_FILT, 32'h3);
		apb(1'b1, ute_pkg::OFS_CFG, (32'h1 << ute_pkg::CFG_EXT_STB) |
			(32'h2 << ute_pkg::CFG_SSEL) | (32'h1 << ute_pkg::CFG_FLT));
		clr();
		apb(1'b1, ute_pkg::OFS_CTRL, 32'h1 << ute_pkg::CTRL_START);
		repeat (5) @(posedge ref_clk);
		// a one-cycle glitch is filtered away, three-cycle pulses pass
		u_src.pulse(2, 1, 1);
		u_src.pulse(2, 3, 4);
		repeat (10) @(posedge ref_clk);
		chk(nstb == 4, "pin strobes");
		chk(np4 == 4 && pin_oe_n === 8'hef, "routed strobe");
		apb(1'b1, ute_pkg::OFS_CTRL, 32'h1 << ute_pkg::CTRL_STOP);
		apb(1'b1, ute_pkg::OFS_CFG, 32'h1 << ute_pkg::CFG_STB_INV);
		repeat (3) @(posedge ref_clk);
		chk(pin_o[4] === 1'b1, "inverted strobe idle");
	endtask

	// ------------------------------------------------------------
	// main sequence: 12 cycles of reset, then the scenarios
	// ------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		internal_hold = 1'b0;
		lvl_evt = 1'b0;
		sample_valid = 1'b1;
		sample_data = 32'h0;
		num_errors = 0;
		n_compared = 0;
		since = 0;
		clr();
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_finite();
		t_pin_launch();
		t_level();
		t_hold();
		t_ext_strobe();
		end_of_test();
	end
endmodule
